// [mswdt_axil.sv]
// AXI4-Lite slave turning bus transfers into single register accesses
`timescale 1ns/100ps

module mswdt_axil
  import mswdt_pkg::*;
(
  input  logic              clk_i,
  input  logic              sys_rst_i,
  input  logic [ADDR_W-1:0] awaddr_i,
  input  logic              awvalid_i,
  output logic              awready_o,
  input  logic [31:0]       wdata_i,
  input  logic [3:0]        wstrb_i,
  input  logic              wvalid_i,
  output logic              wready_o,
  output logic [1:0]        bresp_o,
  output logic              bvalid_o,
  input  logic              bready_i,
  input  logic [ADDR_W-1:0] araddr_i,
  input  logic              arvalid_i,
  output logic              arready_o,
  output logic [31:0]       rdata_o,
  output logic [1:0]        rresp_o,
  output logic              rvalid_o,
  input  logic              rready_i,
  mswdt_reg_if.bus          rif
);
  logic              aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data, next_rdata;
  logic [3:0]        w_strb, next_w_strb;
  logic [1:0]        next_bresp, next_rresp;
  logic              next_bvalid, next_rvalid, next_awready, next_wready;
  logic              next_arready, wr_fire;

  // Address and data may arrive in either order; both are held first
  assign wr_fire     = aw_held && w_held && !bvalid_o;
  assign rif.wr_en   = wr_fire;
  assign rif.wr_addr = aw_addr;
  assign rif.wr_data = w_data;
  assign rif.wr_strb = w_strb;
  assign rif.rd_en   = arvalid_i && arready_o;
  assign rif.rd_addr = araddr_i;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid_o;
    next_bresp   = bresp_o;
    next_rvalid  = rvalid_o;
    next_rdata   = rdata_o;
    next_rresp   = rresp_o;
    if (awvalid_i && awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      next_w_held = 1'b1;
      next_w_data = wdata_i;
      next_w_strb = wstrb_i;
    end
    if (bvalid_o && bready_i) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid_o && rready_i) begin
      next_rvalid = 1'b0;
    end
    if (rif.rd_en) begin
      next_rvalid = 1'b1;
      next_rdata  = rif.rd_data;
      next_rresp  = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      w_held    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= RESP_OKAY;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      arready_o <= 1'b0;
    end else begin
      aw_held   <= next_aw_held;
      aw_addr   <= next_aw_addr;
      w_held    <= next_w_held;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid_o  <= next_bvalid;
      bresp_o   <= next_bresp;
      rvalid_o  <= next_rvalid;
      rdata_o   <= next_rdata;
      rresp_o   <= next_rresp;
      awready_o <= next_awready;
      wready_o  <= next_wready;
      arready_o <= next_arready;
    end
  end
endmodule

// [mswdt_bench.sv]
// Self-checking bench for the multi-stage watchdog top
`timescale 1ns/100ps

module mswdt_bench
  import mswdt_pkg::*;
;
  localparam int unsigned BOOT_T = 20;
  localparam logic [11:0] B1     = 12'h040;

  logic        clk_i = 1'b0, sys_rst_i = 1'b1, boot = 1'b0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic [31:0] w_d = 32'h0000_0000;
  logic [3:0]  w_s = 4'h0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, cpu, core, sysr;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_d;
  logic [3:0]  evts;
  int          cyc = 0;
  int          err_total = 0;
  int          compares = 0;

  assign evts = {sysr, core, cpu, irq};
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  mswdt_top #(.BOOT_CYCLES(BOOT_T)) i_mswdt_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .boot_flash_i(boot),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v),
    .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v),
    .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .irq_o(irq),
    .cpu_rst_req_o(cpu), .core_rst_req_o(core), .sys_rst_req_o(sysr));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic fail(input string nm);
    err_total++;
    $display("[ERR] %s expected answer seen timeout", nm);
    end_of_test();
  endtask

  function automatic logic [11:0] ad(input logic [5:0] o);
    return B1 + {6'h00, o};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    bit ga = 0, gw = 0;
    int n;
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    w_s <= 4'hF;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 40 && !(ga && gw); n++) begin
      @(negedge clk_i);
      ga = ga | (aw_rdy === 1'b1);
      gw = gw | (w_rdy === 1'b1);
      @(posedge clk_i);
      aw_v <= !ga;
      w_v <= !gw;
    end
    if (!(ga && gw)) fail("write take");
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      if (b_v === 1'b1) break;
    end
    if (n == 40) fail("write response");
    chk("bresp", 32'(er), 32'(b_resp));
    @(posedge clk_i);
    b_r <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      if (ar_rdy === 1'b1) break;
    end
    if (n == 40) fail("read take");
    @(posedge clk_i);
    ar_v <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_i);
      if (r_v === 1'b1) break;
    end
    if (n == 40) fail("read data");
    chk(nm, e, r_d);
    chk("rresp", 32'(er), 32'(r_resp));
    @(posedge clk_i);
    r_r <= 1'b0;
  endtask

  task automatic wait_hi(input logic [3:0] m, input int lim, output int t);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_i);
      if ((evts & m) != 4'h0) break;
    end
    t = cyc;
    if (n == lim) fail("event wait");
  endtask

  task automatic quiet(input int lim);
    logic bad;
    bad = 1'b0;
    repeat (lim) begin
      @(negedge clk_i);
      if (evts[3:1] !== 3'b000) bad = 1'b1;
    end
    chk("no reset request", 32'h0000_0000, 32'(bad));
  endtask

  task automatic do_reset(input logic b, output int t0);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    boot <= b;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t0 = cyc;
  endtask

  task automatic t_boot();
    int t0, t;
    do_reset(1'b1, t0);
    wait_hi(4'b1100, BOOT_T + 40, t);
    chk("boot resets", 32'h0000_0003, 32'(evts[3:2]));
    t = t - t0;
    chk("boot dt", 32'h0000_0001, 32'(t >= BOOT_T && t <= BOOT_T + 8));
    $display("boot test done");
  endtask

  task automatic t_regs();
    int t0;
    do_reset(1'b0, t0);
    quiet(BOOT_T + 20);
    rchk("config", ad(OFF_CONFIG), CFG_RST);
    rchk("timeout2", ad(OFF_TMO0 + 6'h08), TMO_RST);
    rchk("lock", ad(OFF_WPROT), 32'h0000_0001);
    rchk("status", ADDR_IRQ_STATUS, 32'h0000_0000);
    rchk("unmapped", 12'h0C0, 32'h0000_0000, RESP_SLVERR);
    wr(12'h0C0, 32'h0000_0001, RESP_SLVERR);
    wr(ad(OFF_CONFIG), 32'h0000_0003);
    rchk("config locked", ad(OFF_CONFIG), CFG_RST);
    quiet(30);
    $display("register test done");
  endtask

  task automatic t_stages();
    int t, tc, tk, tc2;
    wr(ad(OFF_WPROT), UNLOCK_KEY);
    for (int k = 0; k < 4; k++) begin
      wr(ad(OFF_TMO0 + 6'(4 * k)), 32'(5 + k));
    end
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ad(OFF_CONFIG), 32'h0000_11A2);
    rchk("config", ad(OFF_CONFIG), 32'h0000_01A2);
    wr(ad(OFF_CONFIG), 32'h0000_11A3);
    wait_hi(4'b0001, 40, t);
    wait_hi(4'b0010, 40, tc);
    wait_hi(4'b0100, 40, tk);
    chk("stage2 span", 32'h0000_0007, 32'(tk - tc));
    wait_hi(4'b0010, 40, tc2);
    chk("wrap span", 32'h0000_000C, 32'(tc2 - tk));
    chk("irq held", 32'h0000_0001, 32'(irq));
    wr(ad(OFF_CONFIG), 32'h0000_0000);
    quiet(60);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    @(negedge clk_i);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    @(negedge clk_i);
    chk("irq unmasked", 32'h0000_0001, 32'(irq));
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    @(negedge clk_i);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    rchk("status", ADDR_IRQ_STATUS, 32'h0000_0000);
    $display("stage test done");
  endtask

  task automatic t_feed();
    int t;
    wr(ad(OFF_TMO0), 32'h0000_001E);
    wr(ad(OFF_CONFIG), 32'h0000_0005);
    wr(ad(OFF_WPROT), 32'h0000_0000);
    wr(ad(OFF_TMO0), 32'h0000_0003);
    repeat (5) begin
      wr(ad(OFF_FEED), 32'h0000_0001);
      quiet(12);
    end
    rchk("stage", ad(OFF_STAGE), 32'h0000_0000);
    wait_hi(4'b0010, 40, t);
    rchk("timeout0", ad(OFF_TMO0), 32'h0000_001E);
    $display("feed test done");
  endtask

  initial begin
    t_boot();
    t_regs();
    t_stages();
    t_feed();
    end_of_test();
  end
endmodule

// [mswdt_monitor.sv]
// Checker on the watchdog top ports, bound below
`timescale 1ns/100ps

module mswdt_monitor
  import mswdt_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
  input logic clk_i,
  input logic sys_rst_i,
  input logic s_axi_awvalid_i,
  input logic s_axi_awready_o,
  input logic s_axi_wvalid_i,
  input logic s_axi_wready_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic s_axi_rvalid_o,
  input logic irq_o,
  input logic cpu_rst_req_o,
  input logic core_rst_req_o,
  input logic sys_rst_req_o
);
  logic [31:0] up_cnt;
  always_ff @(posedge clk_i) begin
    up_cnt <= sys_rst_i ? 32'h0000_0000 : up_cnt + 32'h0000_0001;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_wr_answer_two: assert property (s_axi_awvalid_i && s_axi_awready_o
      && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("bad write response timing");
  a_rd_answer_next: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o)
    else $error("late read data");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  a_aw_blocked: assert property (s_axi_awvalid_i && s_axi_awready_o
      |=> !s_axi_awready_o [*2])
    else $error("early write ready");
  a_cpu_one_pulse: assert property (cpu_rst_req_o |=> !cpu_rst_req_o)
    else $error("long cpu reset");
  a_core_one_pulse: assert property (core_rst_req_o |=> !core_rst_req_o)
    else $error("long core reset");
  a_sys_one_pulse: assert property (sys_rst_req_o |=> !sys_rst_req_o)
    else $error("long system reset");
  a_irq_sticky: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid_o))
    else $error("irq fell without write");
  a_boot_min_wait: assert property (sys_rst_req_o
      |-> up_cnt >= BOOT_CYCLES)
    else $error("early system reset");
  a_quiet_reset: assert property ($past(sys_rst_i)
      |-> !(irq_o || cpu_rst_req_o || core_rst_req_o || sys_rst_req_o))
    else $error("event after reset");

  c_cpu: cover property (cpu_rst_req_o);
  c_core: cover property (core_rst_req_o);
  c_sys: cover property (sys_rst_req_o);
  c_irq: cover property ($rose(irq_o));
endmodule

bind mswdt_top mswdt_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) i_mswdt_monitor (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .irq_o(irq_o), .cpu_rst_req_o(cpu_rst_req_o),
  .core_rst_req_o(core_rst_req_o), .sys_rst_req_o(sys_rst_req_o));

// [mswdt_pkg.sv]
// Constants, field layout and register map of the multi-stage watchdog
package mswdt_pkg;

  // Timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned BOOT_TIME_MS  = 1000;
  localparam int unsigned BOOT_CYC      = BOOT_TIME_MS * (CLK_HZ / 1000);

  // Structure
  localparam int unsigned NUM_INST      = 3;
  localparam int unsigned NUM_STAGE     = 4;
  localparam int unsigned ALWAYS_ON_INST = 2;
  localparam int unsigned BOOT_MAIN_INST = 0;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned INST_LSB      = 6;
  localparam int unsigned INST_W        = 2;

  // Register offsets inside one watchdog window
  localparam logic [5:0] OFF_CONFIG     = 6'h00;
  localparam logic [5:0] OFF_TMO0       = 6'h04;
  localparam logic [5:0] TMO_SPAN       = 6'h10;
  localparam logic [5:0] OFF_FEED       = 6'h14;
  localparam logic [5:0] OFF_WPROT      = 6'h18;
  localparam logic [5:0] OFF_COUNT      = 6'h1C;
  localparam logic [5:0] OFF_STAGE      = 6'h20;

  // Shared registers
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h100;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h104;

  // Configuration fields
  localparam int unsigned CFG_EN_BIT    = 0;
  localparam int unsigned CFG_ACT_LSB   = 1;
  localparam int unsigned ACT_W         = 3;

  // Stage actions
  localparam logic [2:0] ACT_OFF        = 3'h0;
  localparam logic [2:0] ACT_IRQ        = 3'h1;
  localparam logic [2:0] ACT_CPU        = 3'h2;
  localparam logic [2:0] ACT_CORE       = 3'h3;
  localparam logic [2:0] ACT_SYS        = 3'h4;

  // Reset and boot values
  localparam logic [31:0] CFG_RST       = 32'h0000_0000;
  localparam logic [31:0] TMO_RST       = 32'h0000_FFFF;
  localparam logic [31:0] BOOT_CFG_AON  = 32'h0000_0009;
  localparam logic [31:0] BOOT_CFG_MAIN = 32'h0000_0007;
  // Arbitrary unlock value
  localparam logic [31:0] UNLOCK_KEY    = 32'h1F2E_3D4C;

  // AXI responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

// [mswdt_reg_if.sv]
// Register access carrier between the bus slave and the register file
`timescale 1ns/100ps

interface mswdt_reg_if
  import mswdt_pkg::*;
();
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input  wr_err, rd_data, rd_err);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// [mswdt_stage.sv]
// Four-stage expiry counter of one watchdog
`timescale 1ns/100ps

module mswdt_stage
  import mswdt_pkg::*;
(
  input  logic                       clk_i,
  input  logic                       sys_rst_i,
  input  logic                       en_i,
  input  logic                       feed_i,
  input  logic [NUM_STAGE-1:0][31:0] timeout_i,
  input  logic [NUM_STAGE-1:0][2:0]  act_i,
  output logic [31:0]                count_o,
  output logic [1:0]                 stage_o,
  output logic                       expire_o,
  output logic [2:0]                 exp_act_o
);
  typedef enum logic [3:0] {
    STG0 = 4'b0001,
    STG1 = 4'b0010,
    STG2 = 4'b0100,
    STG3 = 4'b1000
  } mswdt_stage_t;

  mswdt_stage_t state, next_state, succ;
  logic [1:0]   idx;
  logic [31:0]  next_count;
  logic         next_expire;
  logic [2:0]   next_act;

  always_comb begin
    case (state)
      STG0:    begin idx = 2'h0; succ = STG1; end
      STG1:    begin idx = 2'h1; succ = STG2; end
      STG2:    begin idx = 2'h2; succ = STG3; end
      STG3:    begin idx = 2'h3; succ = STG0; end
      default: begin idx = 2'h0; succ = STG0; end
    endcase
    next_state  = state;
    next_count  = count_o;
    next_expire = 1'b0;
    next_act    = ACT_OFF;
    if (!en_i || feed_i) begin
      next_state = STG0; // (R3) (R11)
      next_count = 32'h0000_0000;
    end else if (act_i[idx] == ACT_OFF) begin
      // A disabled stage is stepped over so the others keep working
      next_state = succ; // (R7)
      next_count = 32'h0000_0000;
    end else if ({1'b0, count_o} + 33'h0_0000_0001 >= {1'b0, timeout_i[idx]}) begin
      next_state  = succ; // (R2) (R11)
      next_count  = 32'h0000_0000;
      next_expire = 1'b1; // (R3)
      next_act    = act_i[idx];
    end else begin
      next_count = count_o + 32'h0000_0001; // (R6)
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state     <= STG0;
      count_o   <= 32'h0000_0000;
      stage_o   <= 2'h0;
      expire_o  <= 1'b0;
      exp_act_o <= ACT_OFF;
    end else begin
      state     <= next_state;
      count_o   <= next_count;
      stage_o   <= (next_state == STG0) ? 2'h0 :
                   (next_state == STG1) ? 2'h1 :
                   (next_state == STG2) ? 2'h2 : 2'h3;
      expire_o  <= next_expire;
      exp_act_o <= next_act;
    end
  end
endmodule

// [mswdt_top.sv]
// Multi-stage watchdog top: three watchdogs, registers and event outputs
`timescale 1ns/100ps

// Behaviour
// (R1) Three watchdogs: two main, one always-on
// (R2) Four stages stepped in order while running
// (R3) Stage expiry acts unless fed or disabled
// (R4) Actions: interrupt, CPU, core, system reset
// (R5) System reset only from always-on watchdog
// (R6) Per-stage timeout, 32-bit expiry counter
// (R7) Each stage configured and disabled separately
// (R8) Write protection guards watchdog configuration
// (R9) Flash boot starts always-on and first main
// (R10) Slow flash boot reboots whole system
// (R11) Feed clears counter; next stage from zero
// (R12) Resets pulse once; interrupt flag sticks
module mswdt_top
  import mswdt_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
  input  logic              clk_i,
  input  logic              sys_rst_i,
  input  logic              boot_flash_i,
  input  logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  logic              s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  logic [31:0]       s_axi_wdata_i,
  input  logic [3:0]        s_axi_wstrb_i,
  input  logic              s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  logic              s_axi_bready_i,
  input  logic [ADDR_W-1:0] s_axi_araddr_i,
  input  logic              s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  logic              s_axi_rready_i,
  output logic              irq_o,
  output logic              cpu_rst_req_o,
  output logic              core_rst_req_o,
  output logic              sys_rst_req_o
);
  if (BOOT_CYCLES == 0) begin : g_chk_boot
    $error("BOOT_CYCLES must be at least one");
  end
  if (NUM_INST > (1 << INST_W) || ALWAYS_ON_INST >= NUM_INST) begin : g_chk
    $error("Instance layout does not fit the address window");
  end

  mswdt_reg_if rif ();

  logic [NUM_INST-1:0][31:0]                 cfg, next_cfg;
  logic [NUM_INST-1:0][NUM_STAGE-1:0][31:0]  tmo, next_tmo;
  logic [NUM_INST-1:0][NUM_STAGE-1:0][2:0]   act;
  logic [NUM_INST-1:0][31:0]                 count;
  logic [NUM_INST-1:0][1:0]                  stage;
  logic [NUM_INST-1:0][2:0]                  exp_act;
  logic [NUM_INST-1:0]                       expire, feed;
  logic [NUM_INST-1:0]                       locked, next_locked;
  logic [NUM_INST-1:0]                       status, next_status;
  logic [NUM_INST-1:0]                       mask, next_mask;
  logic [NUM_INST-1:0]                       irq_set, cpu_ev, core_ev, sys_ev;
  logic                                      boot_done, next_boot_done;
  logic                                      next_irq, next_cpu, next_core;
  logic                                      next_sys;
  logic                                      w_win, r_win;
  logic [INST_W-1:0]                         w_inst, r_inst;
  logic [5:0]                                w_off, r_off, w_rel, r_rel;

  // Keeps only legal actions; system reset is refused off the always-on one
  function automatic logic [31:0] mswdt_clean(input logic [31:0] val,
                                              input logic        aon);
    logic [31:0] r;
    logic [2:0]  a;
    r = 32'h0000_0000;
    r[CFG_EN_BIT] = val[CFG_EN_BIT];
    for (int s = 0; s < NUM_STAGE; s++) begin
      a = val[CFG_ACT_LSB + ACT_W * s +: ACT_W];
      if (a > ACT_SYS || (a == ACT_SYS && !aon)) begin
        a = ACT_OFF; // (R5)
      end
      r[CFG_ACT_LSB + ACT_W * s +: ACT_W] = a; // (R4)
    end
    return r;
  endfunction

  function automatic logic [31:0] mswdt_merge(input logic [31:0] old,
                                              input logic [31:0] val,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8 * b +: 8] = val[8 * b +: 8];
      end
    end
    return r;
  endfunction

  mswdt_axil u_axil (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .rif       (rif)
  );

  // Two main watchdogs and one always-on watchdog share the same core
  for (genvar g = 0; g < NUM_INST; g++) begin : g_wdt
    for (genvar s = 0; s < NUM_STAGE; s++) begin : g_act
      assign act[g][s] = cfg[g][CFG_ACT_LSB + ACT_W * s +: ACT_W]; // (R7)
    end
    mswdt_stage u_stage ( // (R1)
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (cfg[g][CFG_EN_BIT]),
      .feed_i    (feed[g]),
      .timeout_i (tmo[g]),
      .act_i     (act[g]),
      .count_o   (count[g]),
      .stage_o   (stage[g]),
      .expire_o  (expire[g]),
      .exp_act_o (exp_act[g])
    );
    assign irq_set[g] = expire[g] && (exp_act[g] == ACT_IRQ); // (R12)
    assign cpu_ev[g]  = expire[g] && (exp_act[g] == ACT_CPU); // (R4)
    assign core_ev[g] = expire[g] && (exp_act[g] == ACT_CORE); // (R4)
    assign sys_ev[g]  = expire[g] && (exp_act[g] == ACT_SYS); // (R5)
  end

  assign w_inst = rif.wr_addr[INST_LSB +: INST_W];
  assign w_off  = rif.wr_addr[5:0];
  assign w_rel  = w_off - OFF_TMO0;
  assign w_win  = (rif.wr_addr[ADDR_W-1:INST_LSB+INST_W] == '0) &&
                  (int'(w_inst) < NUM_INST);
  assign r_inst = rif.rd_addr[INST_LSB +: INST_W];
  assign r_off  = rif.rd_addr[5:0];
  assign r_rel  = r_off - OFF_TMO0;
  assign r_win  = (rif.rd_addr[ADDR_W-1:INST_LSB+INST_W] == '0) &&
                  (int'(r_inst) < NUM_INST);

  // Register writes, boot arming and sticky status
  always_comb begin
    next_cfg       = cfg;
    next_tmo       = tmo;
    next_locked    = locked;
    next_mask      = mask;
    next_status    = status;
    next_boot_done = 1'b1;
    feed           = '0;
    rif.wr_err     = 1'b0;
    // Strap is caught in the first cycle after reset, not during it
    if (!boot_done && boot_flash_i) begin
      next_cfg[ALWAYS_ON_INST]    = BOOT_CFG_AON; // (R9) (R10)
      next_cfg[BOOT_MAIN_INST]    = BOOT_CFG_MAIN; // (R9)
      next_tmo[ALWAYS_ON_INST][0] = BOOT_CYCLES; // (R10)
      next_tmo[BOOT_MAIN_INST][0] = BOOT_CYCLES;
    end
    if (rif.wr_en) begin
      if (rif.wr_addr == ADDR_IRQ_STATUS) begin
        if (rif.wr_strb[0]) begin
          next_status = status & ~rif.wr_data[NUM_INST-1:0];
        end
      end else if (rif.wr_addr == ADDR_IRQ_MASK) begin
        if (rif.wr_strb[0]) begin
          next_mask = rif.wr_data[NUM_INST-1:0];
        end
      end else if (w_win && w_off == OFF_CONFIG) begin
        if (!locked[w_inst]) begin
          next_cfg[w_inst] = mswdt_clean( // (R8)
            mswdt_merge(cfg[w_inst], rif.wr_data, rif.wr_strb),
            int'(w_inst) == ALWAYS_ON_INST);
        end
      end else if (w_win && w_off >= OFF_TMO0 && w_rel < TMO_SPAN &&
                   w_off[1:0] == 2'h0) begin
        if (!locked[w_inst]) begin
          next_tmo[w_inst][w_rel[3:2]] = mswdt_merge( // (R6) (R8)
            tmo[w_inst][w_rel[3:2]], rif.wr_data, rif.wr_strb);
        end
      end else if (w_win && w_off == OFF_FEED) begin
        feed[w_inst] = 1'b1; // (R11)
      end else if (w_win && w_off == OFF_WPROT) begin
        // Any value other than the key closes the lock again
        next_locked[w_inst] = (rif.wr_data != UNLOCK_KEY); // (R8)
      end else if (w_win && (w_off == OFF_COUNT || w_off == OFF_STAGE)) begin
        rif.wr_err = 1'b0;
      end else begin
        rif.wr_err = 1'b1;
      end
    end
    // An expiry in the clearing cycle is kept
    next_status = next_status | irq_set; // (R12)
  end

  // Read mux; reads have no side effects
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    rif.rd_err  = 1'b0;
    if (rif.rd_addr == ADDR_IRQ_STATUS) begin
      rif.rd_data[NUM_INST-1:0] = status;
    end else if (rif.rd_addr == ADDR_IRQ_MASK) begin
      rif.rd_data[NUM_INST-1:0] = mask;
    end else if (r_win && r_off == OFF_CONFIG) begin
      rif.rd_data = cfg[r_inst];
    end else if (r_win && r_off >= OFF_TMO0 && r_rel < TMO_SPAN &&
                 r_off[1:0] == 2'h0) begin
      rif.rd_data = tmo[r_inst][r_rel[3:2]];
    end else if (r_win && r_off == OFF_FEED) begin
      rif.rd_data = 32'h0000_0000;
    end else if (r_win && r_off == OFF_WPROT) begin
      rif.rd_data[0] = locked[r_inst];
    end else if (r_win && r_off == OFF_COUNT) begin
      rif.rd_data = count[r_inst];
    end else if (r_win && r_off == OFF_STAGE) begin
      rif.rd_data[1:0] = stage[r_inst];
    end else begin
      rif.rd_err = 1'b1;
    end
  end

  // Event outputs; resets are single-cycle requests
  always_comb begin
    next_irq  = |(next_status & next_mask);
    next_cpu  = |cpu_ev; // (R12)
    next_core = |core_ev; // (R12)
    next_sys  = |sys_ev; // (R5) (R12)
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg       <= {NUM_INST{CFG_RST}};
      tmo       <= {(NUM_INST * NUM_STAGE){TMO_RST}};
      locked    <= '1;
      status    <= '0;
      mask      <= '0;
      boot_done <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      tmo       <= next_tmo;
      locked    <= next_locked;
      status    <= next_status;
      mask      <= next_mask;
      boot_done <= next_boot_done;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o          <= 1'b0;
      cpu_rst_req_o  <= 1'b0;
      core_rst_req_o <= 1'b0;
      sys_rst_req_o  <= 1'b0;
    end else begin
      irq_o          <= next_irq;
      cpu_rst_req_o  <= next_cpu;
      core_rst_req_o <= next_core;
      sys_rst_req_o  <= next_sys;
    end
  end
endmodule
